// *** hw/sdc_pkg.sv ***
// Package for the delta-sigma converter control bank: offsets, fields, resets, types.
// Assumes a 32-bit APB slave on a single 100 MHz system clock.
package sdc_pkg;

    // ********************************************************************
    // Register byte offsets
    // ********************************************************************
    localparam logic [7:0] OFF_POWER_CTRL   = 8'h00;
    localparam logic [7:0] OFF_GAIN_SELECT  = 8'h04;
    localparam logic [7:0] OFF_INPUT_CONN   = 8'h08;
    localparam logic [7:0] OFF_CHANNEL_SEL  = 8'h0C;
    localparam logic [7:0] OFF_RESULT_LOW   = 8'h10;
    localparam logic [7:0] OFF_RESULT_MID   = 8'h14;
    localparam logic [7:0] OFF_RESULT_HIGH  = 8'h18;
    localparam logic [7:0] OFF_CONV_CTRL0   = 8'h1C;
    localparam logic [7:0] OFF_CONV_CTRL1   = 8'h20;
    localparam logic [7:0] OFF_CLOCK_DIV    = 8'h24;
    localparam logic [7:0] OFF_DAC_HIGH     = 8'h28;
    localparam logic [7:0] OFF_DAC_LOW      = 8'h2C;
    localparam logic [7:0] OFF_DAC_CTRL     = 8'h30;
    localparam logic [7:0] OFF_OPAMP_CTRL   = 8'h34;
    localparam logic [7:0] OFF_RATE_DIV     = 8'h38;

    // ********************************************************************
    // Writable masks and reset values
    // ********************************************************************
    localparam logic [7:0] MASK_POWER_CTRL  = 8'h87;
    localparam logic [7:0] MASK_GAIN_SELECT = 8'h7F;
    localparam logic [7:0] MASK_INPUT_CONN  = 8'h7E;
    localparam logic [7:0] MASK_CHANNEL_SEL = 8'h3F;
    localparam logic [7:0] MASK_CONV_CTRL0  = 8'hFD;
    localparam logic [7:0] MASK_CONV_CTRL1  = 8'hFC;
    localparam logic [7:0] MASK_CLOCK_DIV   = 8'h1F;
    localparam logic [7:0] MASK_DAC_LOW     = 8'h0F;
    localparam logic [7:0] MASK_DAC_CTRL    = 8'hC0;
    localparam logic [7:0] MASK_OPAMP_CTRL  = 8'h8F;
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [7:0] RST_CONV_CTRL0   = 8'h20;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int POS_REG_ENABLE  = 7;
    localparam int POS_REG_BYPASS  = 2;
    localparam int POS_SOFT_RESET  = 7;
    localparam int POS_SLEEP       = 6;
    localparam int POS_POWER_OFF   = 5;
    localparam int POS_OSR_LSB     = 2;
    localparam int POS_FILTER_LSB  = 5;
    localparam int POS_FACTOR_A_ONE    = 7;
    localparam int POS_N_TWELVE    = 6;
    localparam int POS_EOC         = 1;
    localparam int POS_SHORT       = 6;

    // ********************************************************************
    // Rate constants
    // ********************************************************************
    localparam logic [5:0] N_SLOW       = 6'h1E;
    localparam logic [5:0] N_FAST       = 6'h0C;
    localparam logic [4:0] OSR_MAX_LOG2 = 5'h0E;

    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b11
    } sdc_conv_type;

    typedef struct packed {
        logic [7:0] power_ctrl;
        logic [7:0] gain_select;
        logic [7:0] input_conn;
        logic [7:0] channel_sel;
        logic [7:0] conv_ctrl0;
        logic [7:0] conv_ctrl1;
        logic [7:0] clock_div;
        logic [7:0] dac_high;
        logic [7:0] dac_low;
        logic [7:0] dac_shadow;
        logic [7:0] dac_ctrl;
        logic [7:0] opamp_ctrl;
        logic [23:0] result;
    } sdc_regs_type;

    typedef struct packed {
        logic [1:0] voltage_sel;
        logic       regulator_on;
        logic       pull_down_on;
        logic       bypass_on;
        logic       cm_drive_on;
        logic       bandgap_on;
        logic [1:0] reference_gain_sel;
        logic [1:0] converter_gain_sel;
        logic [2:0] amplifier_gain_sel;
        logic       input_ends_short;
        logic [1:0] input_crossover_sel;
        logic [2:0] positive_input_sel;
        logic [2:0] negative_input_sel;
    } sdc_analog_type;

endpackage

// *** hw/sdc_ctrl_bank.sv ***
// Control bank of the delta-sigma converter: APB registers, power gating, rate timing.
// Assumes a 100 MHz system clock, synchronous reset, and modulator bits on this clock.
`timescale 1ns/1ns

// Function
// - Two-bit voltage select picks regulator level 2.4, 2.6, 2.9 or 3.3 V.
// - Enable gates regulator, power-off gates reference; bandgap off only when both off.
// - Disabled regulator draws nothing and is held low by a weak pull-down.
// - Disabled common-mode reference leaves its pin floating; fixed level 1.25 V.
// - Bypass bit at bit 2 of power control; regulator enable at bit 7.
// - Power control bits 6 to 3 read zero and ignore writes.
// - Word rate is master clock over divider times factor_a times oversampling.
// - Master clock is system clock, or system clock over two over field plus one.
// - Sampling clock is master clock divided by 30 or 12 per filter mode.
// - Filter mode also sets factor_a factor to 2 or 1.
// - One-bit modulator stream decimated by sinc filter into 24-bit results.
// - The three 8-bit result registers are read-only.
// - Reference gain code picks 1, 1/2 or 1/4; code 11 reserved.
// - Converter gain code picks gain 1, 2, 4 or 8.
// - Amplifier gain code picks gain 1 through 128 in powers of two.
// - Bit 6 of input connect register shorts the two selected input ends.
// - Inputs arrange as four single-ended or two differential channels.
// - Power-off bit powers down converter whatever sleep and soft reset say.
// - Oversampling code 000 gives 16384, halving each step down to 128.
// - Factor_a 2 doubles samples for normal mode; factor_a 1 gives low latency.
module sdc_ctrl_bank (
    input  wire logic                   SYS_CLK,      // System clock, 100 MHz
    input  wire logic                   SRST,         // Synchronous reset, active high
    input  wire logic                   PSEL,         // APB select
    input  wire logic                   PENABLE,      // APB access phase
    input  wire logic                   PWRITE,       // APB direction
    input  wire logic [7:0]             PADDR,        // APB byte address
    input  wire logic [31:0]            PWDATA,       // APB write data
    output logic      [31:0]            PRDATA,       // APB read data
    output logic                        PREADY,       // APB ready
    output logic                        PSLVERR,      // APB error, unmapped address
    input  wire logic                   MOD_BIT,      // Modulator one-bit stream
    output logic                        SAMPLE_STB,   // Sampling clock strobe
    output logic                        RESULT_STB,   // New result stored
    output sdc_pkg::sdc_analog_type     ANALOG        // Analog control outputs
);

    // ********************************************************************
    // State and next state
    // ********************************************************************
    typedef struct packed {
        sdc_pkg::sdc_regs_type regs;
        sdc_pkg::sdc_conv_type conv;
        logic [5:0]            n_cnt;
        logic [4:0]            mclk_cnt;
        logic                  mclk_half;
        logic [14:0]           osr_cnt;
        logic                  factor_a_phase;
        logic signed [25:0]    acc;
        sdc_pkg::sdc_analog_type latched;
        logic [31:0]           rdata;
        logic                  sample;
        logic                  result_stb;
    } sdc_state_type;

    sdc_state_type s_q;
    sdc_state_type s_d;

    logic       wr_en;
    logic       rd_en;
    logic       addr_hit;
    logic       mclk_tick;
    logic [4:0] osr_log2;
    logic [14:0] osr_last;
    logic       factor_a_one;
    logic       conv_gate;

    // ********************************************************************
    // Bus decode
    // ********************************************************************
    // Zero wait states: every word is a flop or a constant product,
    // so the access phase always completes in its first cycle
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && PENABLE && !PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_hit;

    // Address hit check for all mapped words
    always_comb begin
        unique case (PADDR)
            sdc_pkg::OFF_POWER_CTRL, sdc_pkg::OFF_GAIN_SELECT, sdc_pkg::OFF_INPUT_CONN,
            sdc_pkg::OFF_CHANNEL_SEL, sdc_pkg::OFF_RESULT_LOW, sdc_pkg::OFF_RESULT_MID,
            sdc_pkg::OFF_RESULT_HIGH, sdc_pkg::OFF_CONV_CTRL0, sdc_pkg::OFF_CONV_CTRL1,
            sdc_pkg::OFF_CLOCK_DIV, sdc_pkg::OFF_DAC_HIGH, sdc_pkg::OFF_DAC_LOW,
            sdc_pkg::OFF_DAC_CTRL, sdc_pkg::OFF_OPAMP_CTRL,
            sdc_pkg::OFF_RATE_DIV: addr_hit = 1'b1;
            default:               addr_hit = 1'b0;
        endcase
    end

    // ********************************************************************
    // Rate decode
    // ********************************************************************
    // Master clock: tick every cycle, or every 2*(field+1) cycles
    assign mclk_tick = s_q.regs.clock_div[4:0] == 5'h1F ? 1'b1 :
                       (s_q.mclk_half && s_q.mclk_cnt == s_q.regs.clock_div[4:0]);
    // Pass length is a power of two, so the last index is all ones
    assign osr_log2 = sdc_pkg::OSR_MAX_LOG2
                      - {2'b00, s_q.regs.conv_ctrl0[sdc_pkg::POS_OSR_LSB +: 3]};
    assign osr_last = 15'((32'd1 << osr_log2) - 32'd1);
    assign factor_a_one = s_q.regs.conv_ctrl1[sdc_pkg::POS_FACTOR_A_ONE];
    // Power-off overrides sleep and soft reset
    assign conv_gate = !s_q.regs.conv_ctrl0[sdc_pkg::POS_POWER_OFF]
                       && !s_q.regs.conv_ctrl0[sdc_pkg::POS_SLEEP]
                       && !s_q.regs.conv_ctrl0[sdc_pkg::POS_SOFT_RESET];

    // ********************************************************************
    // Next-state logic
    // ********************************************************************
    // Register writes, rate counters, sinc accumulation
    always_comb begin
        s_d = s_q;
        s_d.sample = 1'b0;
        s_d.result_stb = 1'b0;
        if (wr_en) begin
            unique case (PADDR)
                sdc_pkg::OFF_POWER_CTRL:   // Unused bits dropped
                    s_d.regs.power_ctrl = PWDATA[7:0] & sdc_pkg::MASK_POWER_CTRL;
                sdc_pkg::OFF_GAIN_SELECT:
                    s_d.regs.gain_select = PWDATA[7:0] & sdc_pkg::MASK_GAIN_SELECT;
                sdc_pkg::OFF_INPUT_CONN:
                    s_d.regs.input_conn = PWDATA[7:0] & sdc_pkg::MASK_INPUT_CONN;
                sdc_pkg::OFF_CHANNEL_SEL:
                    s_d.regs.channel_sel = PWDATA[7:0] & sdc_pkg::MASK_CHANNEL_SEL;
                sdc_pkg::OFF_CONV_CTRL0:
                    s_d.regs.conv_ctrl0 = PWDATA[7:0] & sdc_pkg::MASK_CONV_CTRL0;
                sdc_pkg::OFF_CONV_CTRL1: begin
                    // Status bit set by hardware and cleared only by a 0 write; data fields written as given
                    // Writing 1 to the end flag keeps it, writing 0 clears it
                    s_d.regs.conv_ctrl1 = (PWDATA[7:0] & sdc_pkg::MASK_CONV_CTRL1)
                                        | (s_q.regs.conv_ctrl1 & 8'h02);
                    if (!PWDATA[sdc_pkg::POS_EOC])
                        s_d.regs.conv_ctrl1[sdc_pkg::POS_EOC] = 1'b0;
                end
                sdc_pkg::OFF_CLOCK_DIV:
                    s_d.regs.clock_div = PWDATA[7:0] & sdc_pkg::MASK_CLOCK_DIV;
                sdc_pkg::OFF_DAC_HIGH: begin
                    // High write releases the shadowed low nibble
                    // Both halves change in one cycle, so no mixed code is seen
                    s_d.regs.dac_high = PWDATA[7:0];
                    s_d.regs.dac_low = s_q.regs.dac_shadow;
                end
                sdc_pkg::OFF_DAC_LOW:
                    s_d.regs.dac_shadow = PWDATA[7:0] & sdc_pkg::MASK_DAC_LOW;
                sdc_pkg::OFF_DAC_CTRL:
                    s_d.regs.dac_ctrl = PWDATA[7:0] & sdc_pkg::MASK_DAC_CTRL;
                sdc_pkg::OFF_OPAMP_CTRL:
                    s_d.regs.opamp_ctrl = PWDATA[7:0] & sdc_pkg::MASK_OPAMP_CTRL;
                default: ;                 // Result words ignore writes
            endcase
        end
        // Master clock divider
        // Runs even while idle so its phase is always defined
        if (s_q.mclk_cnt == s_q.regs.clock_div[4:0]) begin
            s_d.mclk_cnt = 5'h00;
            s_d.mclk_half = !s_q.mclk_half;
        end else begin
            s_d.mclk_cnt = s_q.mclk_cnt + 5'h01;
        end
        // Conversion sequencer: off, one idle cycle, then the sampling run
        unique case (s_q.conv)
            sdc_pkg::ST_OFF: begin
                // Clearing here keeps a stale partial sum out of the next result
                s_d.acc = '0;
                s_d.osr_cnt = '0;
                s_d.factor_a_phase = 1'b0;
                s_d.n_cnt = '0;
                if (conv_gate) begin
                    s_d.conv = sdc_pkg::ST_IDLE;
                end
            end
            sdc_pkg::ST_IDLE: begin
                // Settings captured at the start of a conversion
                // The idle cycle costs one system clock between results
                s_d.latched = ANALOG;
                s_d.conv = conv_gate ? sdc_pkg::ST_RUN : sdc_pkg::ST_OFF;
            end
            sdc_pkg::ST_RUN: begin
                if (!conv_gate) begin
                    s_d.conv = sdc_pkg::ST_OFF;  // Abort drops partial data
                end else if (mclk_tick) begin
                    // Sampling clock from master over N
                    if (s_q.n_cnt == (s_q.regs.conv_ctrl1[sdc_pkg::POS_N_TWELVE]
                                      ? sdc_pkg::N_FAST : sdc_pkg::N_SLOW) - 6'h01) begin
                        s_d.n_cnt = '0;
                        s_d.sample = 1'b1;
                        // Sinc accumulation of the bit stream
                        s_d.acc = s_q.acc + (MOD_BIT ? 26'sd1 : -26'sd1);
                        s_d.osr_cnt = s_q.osr_cnt + 15'h0001;
                        if (s_q.osr_cnt == osr_last) begin
                            s_d.osr_cnt = '0;
                            // Factor_a 2 needs a second pass
                            if (factor_a_one || s_q.factor_a_phase) begin
                                s_d.factor_a_phase = 1'b0;
                                s_d.regs.result = s_d.acc[23:0];
                                s_d.regs.conv_ctrl1[sdc_pkg::POS_EOC] = 1'b1;
                                s_d.result_stb = 1'b1;
                                s_d.acc = '0;
                                s_d.conv = sdc_pkg::ST_IDLE;
                            end else begin
                                s_d.factor_a_phase = 1'b1;
                            end
                        end
                    end else begin
                        s_d.n_cnt = s_q.n_cnt + 6'h01;
                    end
                end
            end
            default: s_d.conv = sdc_pkg::ST_OFF;
        endcase
        // Register read mux
        // Reads have no side effects, so software may poll freely
        s_d.rdata = '0;
        if (rd_en) begin
            unique case (PADDR)
                sdc_pkg::OFF_POWER_CTRL:  s_d.rdata[7:0] = s_q.regs.power_ctrl;
                sdc_pkg::OFF_GAIN_SELECT: s_d.rdata[7:0] = s_q.regs.gain_select;
                sdc_pkg::OFF_INPUT_CONN:  s_d.rdata[7:0] = s_q.regs.input_conn;
                sdc_pkg::OFF_CHANNEL_SEL: s_d.rdata[7:0] = s_q.regs.channel_sel;
                sdc_pkg::OFF_RESULT_LOW:  s_d.rdata[7:0] = s_q.regs.result[7:0];
                sdc_pkg::OFF_RESULT_MID:  s_d.rdata[7:0] = s_q.regs.result[15:8];
                sdc_pkg::OFF_RESULT_HIGH: s_d.rdata[7:0] = s_q.regs.result[23:16];
                sdc_pkg::OFF_CONV_CTRL0:  s_d.rdata[7:0] = s_q.regs.conv_ctrl0;
                sdc_pkg::OFF_CONV_CTRL1:  s_d.rdata[7:0] = s_q.regs.conv_ctrl1;
                sdc_pkg::OFF_CLOCK_DIV:   s_d.rdata[7:0] = s_q.regs.clock_div;
                sdc_pkg::OFF_DAC_HIGH:    s_d.rdata[7:0] = s_q.regs.dac_high;
                sdc_pkg::OFF_DAC_LOW:     s_d.rdata[7:0] = s_q.regs.dac_low;
                sdc_pkg::OFF_DAC_CTRL:    s_d.rdata[7:0] = s_q.regs.dac_ctrl;
                sdc_pkg::OFF_OPAMP_CTRL:  s_d.rdata[7:0] = s_q.regs.opamp_ctrl;
                // Divider product N*factor_a view
                sdc_pkg::OFF_RATE_DIV:    s_d.rdata[20:0] = 21'((factor_a_one ? 32'd1 : 32'd2)
                    * {26'd0, (s_q.regs.conv_ctrl1[sdc_pkg::POS_N_TWELVE]
                               ? sdc_pkg::N_FAST : sdc_pkg::N_SLOW)});
                default:                  s_d.rdata = '0;
            endcase
        end
    end

    // ********************************************************************
    // State register
    // ********************************************************************
    // Every flop runs each edge; reset loads constants only
    // Synchronous reset keeps the whole state in one plain flop bank
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            s_q <= '0;
            s_q.regs.conv_ctrl0 <= sdc_pkg::RST_CONV_CTRL0;
            s_q.conv <= sdc_pkg::ST_OFF;
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    // Read data comes straight from the mux in the access cycle; the registered copy holds for one cycle after it, then reads zero
    assign PRDATA = rd_en ? s_d.rdata : s_q.rdata;
    assign SAMPLE_STB = s_q.sample;
    assign RESULT_STB = s_q.result_stb;

    // Analog controls follow register fields directly
    // Gains act at once on the analog side; the copy taken at the start
    // of each conversion feeds only the latch_stable_a check
    always_comb begin
        ANALOG.voltage_sel = s_q.regs.power_ctrl[1:0];
        ANALOG.regulator_on = s_q.regs.power_ctrl[sdc_pkg::POS_REG_ENABLE];
        ANALOG.pull_down_on = !s_q.regs.power_ctrl[sdc_pkg::POS_REG_ENABLE];
        ANALOG.bypass_on = s_q.regs.power_ctrl[sdc_pkg::POS_REG_BYPASS];
        ANALOG.cm_drive_on = !s_q.regs.conv_ctrl0[sdc_pkg::POS_POWER_OFF];
        ANALOG.bandgap_on = ANALOG.regulator_on || ANALOG.cm_drive_on;
        ANALOG.reference_gain_sel = s_q.regs.gain_select[6:5];
        ANALOG.converter_gain_sel = s_q.regs.gain_select[4:3];
        ANALOG.amplifier_gain_sel = s_q.regs.gain_select[2:0];
        ANALOG.input_ends_short = s_q.regs.input_conn[sdc_pkg::POS_SHORT];
        ANALOG.input_crossover_sel = s_q.regs.input_conn[5:4];
        ANALOG.positive_input_sel = s_q.regs.channel_sel[2:0];
        ANALOG.negative_input_sel = s_q.regs.channel_sel[5:3];
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************
    // Power map checks against the raw register bits
    power_gap_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        ANALOG.bandgap_on == (s_q.regs.power_ctrl[sdc_pkg::POS_REG_ENABLE]
                              || !s_q.regs.conv_ctrl0[sdc_pkg::POS_POWER_OFF]))
        else $error("bandgap state wrong");
    pull_down_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        ANALOG.pull_down_on == !s_q.regs.power_ctrl[sdc_pkg::POS_REG_ENABLE])
        else $error("pull-down not opposite regulator");
    unused_zero_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        s_q.regs.power_ctrl[6:3] == 4'h0)
        else $error("power control unused bits set");
    // Conversion order checks
    power_off_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        s_q.regs.conv_ctrl0[sdc_pkg::POS_POWER_OFF] |=> s_q.conv != sdc_pkg::ST_RUN)
        else $error("converter runs while off");
    result_hold_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        !s_q.result_stb |-> $stable(s_q.regs.result))
        else $error("result changed without strobe");
    sample_rate_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        SAMPLE_STB && s_q.regs.clock_div[4:0] == 5'h1F
        && s_q.regs.conv_ctrl1[sdc_pkg::POS_N_TWELVE] && conv_gate
        && $stable(s_q.regs.conv_ctrl1) |=> !SAMPLE_STB [*8])
        else $error("sample strobes too close");
    latch_stable_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        s_q.conv == sdc_pkg::ST_RUN && $past(s_q.conv) == sdc_pkg::ST_RUN
        |-> $stable(s_q.latched))
        else $error("settings changed mid conversion");
    rate_read_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        rd_en && PADDR == sdc_pkg::OFF_RATE_DIV && !factor_a_one
        && !s_q.regs.conv_ctrl1[sdc_pkg::POS_N_TWELVE] |-> PRDATA == 32'h0000003C)
        else $error("rate divider wrong");

    // ********************************************************************
    // Assertions on rate, conversion timing and reference power
    // ********************************************************************
    // Each result sets the end flag in the same cycle
    eoc_set_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        RESULT_STB |-> s_q.regs.conv_ctrl1[sdc_pkg::POS_EOC])
        else $error("end flag not set with result");
    // Strobes only come out of a running conversion
    sample_run_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        SAMPLE_STB |-> $past(s_q.conv) == sdc_pkg::ST_RUN)
        else $error("sample strobe outside a conversion");
    // Shortest and longest oversampling passes
    osr_short_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        s_q.regs.conv_ctrl0[sdc_pkg::POS_OSR_LSB +: 3] == 3'h7 |-> osr_last == 15'h007F)
        else $error("short oversampling count wrong");
    osr_long_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        s_q.regs.conv_ctrl0[sdc_pkg::POS_OSR_LSB +: 3] == 3'h0 |-> osr_last == 15'h3FFF)
        else $error("long oversampling count wrong");
    // Divided master clock never ticks on two edges in a row
    mclk_half_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        mclk_tick && s_q.regs.clock_div[4:0] != 5'h1F && $stable(s_q.regs.clock_div)
        |=> !mclk_tick || !$stable(s_q.regs.clock_div))
        else $error("divided master clock too fast");
    // A powered-down reference is never driven
    cm_float_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        s_q.regs.conv_ctrl0[sdc_pkg::POS_POWER_OFF] |-> !ANALOG.cm_drive_on)
        else $error("reference driven while off");

endmodule // sdc_ctrl_bank

// *** tb/tb.sv ***
// Testbench for the converter control bank: register traffic, analog controls, rate timing.
// Assumes a zero-wait APB slave; conversions use the shortest count settings.
`timescale 1ns/1ns
module tb;
    logic                   sys_clk, srst, psel, penable, pwrite, mod_bit;
    logic [7:0]             paddr;
    logic [31:0]            pwdata, prdata, d, r;
    logic                   pready, pslverr, sample_stb, result_stb, e;
    sdc_pkg::sdc_analog_type analog;
    int                     n_errors, checks_done, n;

    sdc_ctrl_bank i_dut (.SYS_CLK(sys_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .MOD_BIT(mod_bit), .SAMPLE_STB(sample_stb),
        .RESULT_STB(result_stb), .ANALOG(analog));

    // ****************************************************************
    // Clock and shared tasks
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; an extra edge after release keeps strobes from colliding
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        e = pslverr;
        if (k >= 50) begin
            n_errors++;
            close_out();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    // Expected rate divider: N times factor_a for a filter mode code
    function automatic int rate_exp(input int f);
        return (f[0] ? 12 : 30) * (f[1] ? 1 : 2);
    endfunction

    // Cycles from one sampling strobe to the next, bounded
    task automatic spacing();
        n = 0;
        while (sample_stb !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        if (n < 200) begin
            n = 0;
            do begin
                @(posedge sys_clk);
                n++;
            end while (sample_stb !== 1'b1 && n < 200);
        end
        if (n >= 200) begin
            n_errors++;
            close_out();
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata, mod_bit} = {1'b1, 43'h0, 1'b1};
        n_errors = 0;
        checks_done = 0;
        void'($urandom(29256));
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        apb(0, sdc_pkg::OFF_CONV_CTRL0, 0);
        check(r, 32'h20);
        check({analog.bandgap_on, analog.pull_down_on}, 2'b01);
        // Random control words, fields checked at the analog outputs
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            apb(1, sdc_pkg::OFF_POWER_CTRL, d);
            apb(0, sdc_pkg::OFF_POWER_CTRL, 0);
            check(r, {24'h0, d[7:0] & 8'h87});
            check(analog.voltage_sel, d[1:0]);
            check({analog.regulator_on, analog.bypass_on, analog.pull_down_on},
                  {d[7], d[2], ~d[7]});
            check({analog.bandgap_on, analog.cm_drive_on}, {d[7], 1'b0});
            apb(1, sdc_pkg::OFF_GAIN_SELECT, d >> 8);
            check({analog.reference_gain_sel, analog.converter_gain_sel,
                   analog.amplifier_gain_sel}, d[14:8]);
            apb(1, sdc_pkg::OFF_INPUT_CONN, d >> 16);
            check(analog.input_ends_short, d[22]);
            check(analog.input_crossover_sel, d[21:20]);
            apb(1, sdc_pkg::OFF_CHANNEL_SEL, d >> 24);
            check({analog.negative_input_sel, analog.positive_input_sel}, d[29:24]);
        end
        // Refused accesses
        apb(1, sdc_pkg::OFF_RESULT_LOW, 32'hFF);
        apb(0, sdc_pkg::OFF_RESULT_LOW, 0);
        check(r, 0);
        apb(0, 8'h3C, 0);
        check({e, r}, {1'b1, 32'h0});
        // Every filter mode code: N times factor_a
        for (int f = 0; f < 4; f++) begin
            apb(1, sdc_pkg::OFF_CONV_CTRL1, {24'h0, f[1:0], 6'h00});
            apb(0, sdc_pkg::OFF_RATE_DIV, 0);
            check(r, rate_exp(f));
        end
        // Short conversion, all samples +1: result equals the sample count
        apb(1, sdc_pkg::OFF_CLOCK_DIV, 32'h1F);
        apb(1, sdc_pkg::OFF_CONV_CTRL0, 32'h1C);
        check(analog.cm_drive_on, 1'b1);
        spacing();
        check(n, 12);
        n = 0;
        while (result_stb !== 1'b1 && n < 5000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 5000) begin
            n_errors++;
            close_out();
        end
        apb(0, sdc_pkg::OFF_RESULT_LOW, 0);
        check(r, 32'h80);
        apb(0, sdc_pkg::OFF_RESULT_MID, 0);
        check(r, 0);
        apb(1, sdc_pkg::OFF_CLOCK_DIV, 0);
        spacing();
        check(n, 24);
        apb(1, sdc_pkg::OFF_CONV_CTRL0, 32'h3C);
        // Powered down: no strobe may appear in a fixed window
        n = 0;
        repeat (200) begin
            @(posedge sys_clk);
            if (sample_stb !== 1'b0) n++;
        end
        check({analog.cm_drive_on, n[7:0]}, 9'h000);
        close_out();
    end
endmodule // tb
